// *** logic/scan_reg_pkg.sv ***
// Purpose: constants shared by the scannable register and its capture FIFO
// Assumes: one clock, CLK_SYS at 250 MHz
// Notes: mode codes are also shown on the LAST_OP port
//
// What this block does
// - A high shift select forces a serial shift on the clock edge, whatever the hold/load select says.
// - With shift select low, hold/load select high holds the contents and low loads all parallel inputs.
// - The register is 8 bits wide, fed by eight parallel inputs and shown on eight outputs.
// - In shift mode the serial input enters the chain and the contents move one place per rising edge.
// - Load, hold and shift all happen on the rising clock edge using the inputs present just before it.
// - A high master reset clears every register bit at once, without the clock, over both selects.
package scan_reg_pkg;

    // ********************************
    // Sizes and timing
    // ********************************
    localparam int REG_WIDTH = 8;
    localparam int CAP_DEPTH = 8;
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_FREQ_MHZ = 1000 / CLK_PERIOD_NS;

    // ********************************
    // Reset values and operations
    // ********************************
    localparam logic [REG_WIDTH-1:0] REG_RESET_VALUE = 8'h00;

    typedef enum logic [1:0] {
        OP_LOAD = 2'b00,
        OP_HOLD = 2'b01,
        OP_SHIFT = 2'b10,
        OP_CLEAR = 2'b11
    } op_e;

endpackage : scan_reg_pkg

// *** logic/scan_reg_fifo.sv ***
// Purpose: capture FIFO for words taken in by parallel loads
// Assumes: single clock, asynchronous active-low reset
// Notes: head word sits in an output register; storage behind it holds DEPTH words
`timescale 1ns/1ns
module scan_reg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, next_wr_ptr;
    logic [PW-1:0] rd_ptr, next_rd_ptr;
    logic [PW:0] count, next_count;
    logic next_in_ready;
    logic next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic mem_write;

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        logic push;
        logic head_free;
        push = in_valid && in_ready;
        head_free = !out_valid || out_ready;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        next_out_valid = out_valid;
        next_out_data = out_data;
        mem_write = 1'b0;
        if (head_free) begin
            if (count != '0) begin
                next_out_valid = 1'b1;
                next_out_data = mem[rd_ptr];
                next_rd_ptr = PW'(rd_ptr + 1'b1);
                next_count = (PW+1)'(next_count - 1'b1);
            end else if (push) begin
                // Bypass straight to the head when storage is empty
                next_out_valid = 1'b1;
                next_out_data = in_data;
            end else begin
                next_out_valid = 1'b0;
            end
        end
        if (push && !(head_free && count == '0)) begin
            mem_write = 1'b1;
            next_wr_ptr = PW'(wr_ptr + 1'b1);
            next_count = (PW+1)'(next_count + 1'b1);
        end
        // Registered full flag keeps in_ready glitch-free for the source
        next_in_ready = (next_count != (PW+1)'(DEPTH));
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_write) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : scan_reg_fifo

// *** logic/scan_reg.sv ***
// Purpose: 8-bit scannable register with load, hold, shift and master clear
// Assumes: all inputs synchronous to CLK_SYS except RST_N and MASTER_RESET
// Notes: every loaded word that finds room is also queued in a capture FIFO for a downstream reader
`timescale 1ns/1ns
module scan_reg
    import scan_reg_pkg::*;
#(
    parameter int WIDTH = scan_reg_pkg::REG_WIDTH,
    parameter int DEPTH = scan_reg_pkg::CAP_DEPTH
) (
    // Clock and resets
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic MASTER_RESET,
    // Mode selects
    input wire logic SHIFT_SELECT,
    input wire logic HOLD_LOAD_SELECT,
    // Data in
    input wire logic [WIDTH-1:0] PARALLEL_IN,
    input wire logic SERIAL_IN,
    // Register contents
    output logic [WIDTH-1:0] REG_OUT,
    output scan_reg_pkg::op_e LAST_OP,
    // Capture stream
    output logic [WIDTH-1:0] CAP_DATA,
    output logic CAP_VALID,
    input wire logic CAP_READY,
    output logic LOAD_READY,
    output logic CAP_OVERFLOW
);
    import scan_reg_pkg::*;

    logic clear_n;
    op_e op;
    logic [WIDTH-1:0] next_reg_out;
    logic next_overflow;
    logic cap_push;

    // Either reset clears the register at once, with no clock edge needed
    assign clear_n = RST_N & ~MASTER_RESET;

    // ********************************
    // Operation select
    // ********************************
    always_comb begin
        if (MASTER_RESET) begin
            op = OP_CLEAR;
        end else if (SHIFT_SELECT) begin
            op = OP_SHIFT;
        end else if (HOLD_LOAD_SELECT) begin
            op = OP_HOLD;
        end else begin
            op = OP_LOAD;
        end
    end

    // ********************************
    // Register next value
    // ********************************
    always_comb begin
        case (op)
            OP_SHIFT: next_reg_out = {REG_OUT[WIDTH-2:0], SERIAL_IN};
            OP_LOAD: next_reg_out = PARALLEL_IN;
            OP_HOLD: next_reg_out = REG_OUT;
            OP_CLEAR: next_reg_out = REG_RESET_VALUE;
            default: next_reg_out = REG_OUT;
        endcase
        // A load with no room is dropped from the stream, never stalls the register
        cap_push = (op == OP_LOAD);
        next_overflow = CAP_OVERFLOW | (cap_push & ~LOAD_READY);
    end

    always_ff @(posedge CLK_SYS or negedge clear_n) begin
        if (!clear_n) begin
            REG_OUT <= REG_RESET_VALUE;
            LAST_OP <= OP_CLEAR;
        end else begin
            REG_OUT <= next_reg_out;
            LAST_OP <= op;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            CAP_OVERFLOW <= 1'b0;
        end else begin
            CAP_OVERFLOW <= next_overflow;
        end
    end

    // ********************************
    // Capture FIFO
    // ********************************
    scan_reg_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) u_cap_fifo (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .in_valid(cap_push),
        .in_data(PARALLEL_IN),
        .in_ready(LOAD_READY),
        .out_valid(CAP_VALID),
        .out_data(CAP_DATA),
        .out_ready(CAP_READY)
    );

endmodule : scan_reg

// *** bench/scan_reg_chk.sv ***
// Purpose: port assertions for scan_reg
// Assumes: one clock, RST_N async low
// Notes: ok marks two edges free of any reset
`timescale 1ns/1ns
module scan_reg_chk
    import scan_reg_pkg::*;
#(parameter int WIDTH = 8) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic MASTER_RESET,
    input wire logic SHIFT_SELECT,
    input wire logic HOLD_LOAD_SELECT,
    input wire logic [WIDTH-1:0] PARALLEL_IN,
    input wire logic SERIAL_IN,
    input wire logic [WIDTH-1:0] REG_OUT,
    input scan_reg_pkg::op_e LAST_OP,
    input wire logic [WIDTH-1:0] CAP_DATA,
    input wire logic CAP_VALID,
    input wire logic CAP_READY,
    input wire logic LOAD_READY,
    input wire logic CAP_OVERFLOW
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic run;
    wire ld = !SHIFT_SELECT && !HOLD_LOAD_SELECT;
    always_ff @(posedge CLK_SYS) run <= RST_N && !MASTER_RESET;
    wire ok = run && !MASTER_RESET;
    a_shift_move: assert property (ok && $past(SHIFT_SELECT)
        |-> REG_OUT == {$past(REG_OUT[WIDTH-2:0]), $past(SERIAL_IN)}) else $error("shift wrong");
    a_hold_keep: assert property (ok && $past(!SHIFT_SELECT && HOLD_LOAD_SELECT)
        |-> $stable(REG_OUT)) else $error("hold wrong");
    a_load_take: assert property (ok && $past(ld)
        |-> REG_OUT == $past(PARALLEL_IN)) else $error("load wrong");
    a_clear_now: assert property (MASTER_RESET
        |-> REG_OUT == '0 && LAST_OP == OP_CLEAR) else $error("clear wrong");
    a_op_code: assert property (ok
        |-> LAST_OP == ($past(SHIFT_SELECT) ? OP_SHIFT : $past(ld) ? OP_LOAD : OP_HOLD)) else $error("op wrong");
    a_cap_first: assert property (ok && $past(ld && LOAD_READY && !CAP_VALID)
        |-> CAP_VALID && CAP_DATA == $past(PARALLEL_IN)) else $error("capture wrong");
    a_cap_stand: assert property (CAP_VALID && !CAP_READY
        |=> CAP_VALID && $stable(CAP_DATA)) else $error("head moved");
    a_ovf_set: assert property (ok && $past(ld && !LOAD_READY)
        |-> CAP_OVERFLOW) else $error("overflow missed");
endmodule : scan_reg_chk
bind scan_reg scan_reg_chk #(.WIDTH(WIDTH)) u_scan_reg_chk (.*);

// *** bench/cap_reader.sv ***
// Purpose: downstream reader of the capture stream
// Assumes: stall changes just after a rising edge
// Notes: stall holds ready low so the FIFO fills
`timescale 1ns/1ns
module cap_reader (
    input wire logic clk,
    input wire logic stall,
    output logic ready
);
    assign ready = !stall;
endmodule : cap_reader

// *** bench/tb_scan_reg.sv ***
// Purpose: self-checking bench for scan_reg
// Assumes: 4 ns clock, inputs driven 1 ns after each rising edge
// Notes: expected words follow from the driven selects and data alone
`timescale 1ns/1ns
module tb_scan_reg;
    import scan_reg_pkg::*;
    logic clk = 0, rst_n = 0, mr = 0, sh = 0, hl = 1, si = 0, stall = 1;
    logic [7:0] d = 8'h00, exp, q, cd;
    op_e op;
    logic cv, lr, ovf, cr;
    int failures = 0, total_checks = 0, cycles = 0;
    always #2 clk = ~clk;
    scan_reg u_scan_reg (.CLK_SYS(clk), .RST_N(rst_n), .MASTER_RESET(mr), .SHIFT_SELECT(sh),
        .HOLD_LOAD_SELECT(hl), .PARALLEL_IN(d), .SERIAL_IN(si), .REG_OUT(q), .LAST_OP(op),
        .CAP_DATA(cd), .CAP_VALID(cv), .CAP_READY(cr), .LOAD_READY(lr), .CAP_OVERFLOW(ovf));
    cap_reader u_cap_reader (.clk(clk), .stall(stall), .ready(cr));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic step(logic s, logic h, logic [7:0] v, logic b);
        sh = s;
        hl = h;
        d = v;
        si = b;
        @(posedge clk);
        #1;
    endtask : step
    task automatic t_shift;
        logic b;
        exp = 8'h00;
        for (int i = 0; i < 9; i++) begin
            b = i[1] ^ i[0];
            step(1, i[0], 8'hFF, b);
            exp = {exp[6:0], b};
            chk("shift", exp, q);
            chk("op", OP_SHIFT, op);
        end
        $display("t_shift done");
    endtask : t_shift
    task automatic t_load_hold;
        step(0, 0, 8'hA5, 1);
        chk("load", 8'hA5, q);
        chk("op", OP_LOAD, op);
        step(0, 1, 8'h3C, 0);
        chk("hold", 8'hA5, q);
        chk("op", OP_HOLD, op);
        step(0, 0, 8'h5A, 1);
        step(0, 0, 8'h81, 1);
        chk("back", 8'h81, q);
        $display("t_load_hold done");
    endtask : t_load_hold
    task automatic t_clear;
        sh = 1;
        si = 1;
        mr = 1;
        #1;
        chk("clear", 8'h00, q);
        chk("op", OP_CLEAR, op);
        @(posedge clk);
        #1;
        chk("held", 8'h00, q);
        mr = 0;
        step(0, 0, 8'h42, 0);
        chk("after", 8'h42, q);
        $display("t_clear done");
    endtask : t_clear
    task automatic t_fifo;
        stall = 0;
        repeat (12) step(0, 1, 8'h00, 0);
        chk("empty", 8'h00, cv);
        chk("ovf0", 8'h00, ovf);
        stall = 1;
        for (int i = 0; i < 10; i++) step(0, 0, {4'h1, i[3:0]}, 0);
        chk("ready", 8'h00, lr);
        chk("ovf", 8'h01, ovf);
        stall = 0;
        for (int i = 0; i < 9; i++) begin
            chk("valid", 8'h01, cv);
            chk("word", {4'h1, i[3:0]}, cd);
            step(0, 1, 8'h00, 0);
        end
        chk("drained", 8'h00, cv);
        // Mid-run reset must clear the sticky overflow and free the FIFO
        rst_n = 0;
        #1;
        chk("rst ovf", 8'h00, ovf);
        chk("rst ready", 8'h01, lr);
        chk("rst q", 8'h00, q);
        @(posedge clk);
        #1;
        rst_n = 1;
        step(0, 0, 8'h24, 0);
        chk("post rst", 8'h24, q);
        $display("t_fifo done");
    endtask : t_fifo
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cycles++;
        if (cycles == 400) begin
            failures++;
            conclude;
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        chk("rst op", OP_CLEAR, op);
        rst_n = 1;
        chk("rst", 8'h00, q);
        t_shift;
        t_load_hold;
        t_clear;
        t_fifo;
        conclude;
    end
endmodule : tb_scan_reg
